// file: src/module_mgmt_control_pins.sv
// Behaviour
// - Answer serial commands only while module select is held low.
// - Host reads and writes the management map over clock and data lines.
// - Reset pin low beyond least pulse length restores all default settings.
// - Completion shown by interrupt low with data-not-ready bit negated.
// - Power-up raises the completion interrupt without a reset pulse.
// - Low-power input limits the module's maximum power.
// - Presence output tied to ground while inserted.
// - Interrupt low flags a fault or critical status.
// - Interrupt only pulled low or released; host supplies the pull-up.
`timescale 1ns/1ns
`include "mgmt_regs.svh"
module module_mgmt_control_pins import mgmt_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic moduleSelectN,
  input wire logic moduleResetN,
  input wire logic lowPowerRequest,
  input wire logic statusAlarm,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOeN,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  output logic presenceNOut,
  output logic presenceNOeN,
  output logic attentionIrqNOut,
  output logic attentionIrqNOeN,
  output logic highPowerEnable,
  output logic dataNotReady
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] selSync_r;
  logic [1:0] rstSync_r;
  logic [1:0] lpSync_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      selSync_r <= 2'h3;
      rstSync_r <= 2'h3;
      lpSync_r <= 2'h3;
    end else begin
      selSync_r <= {selSync_r[0], moduleSelectN};
      rstSync_r <= {rstSync_r[0], moduleResetN};
      lpSync_r <= {lpSync_r[0], lowPowerRequest};
    end
  end

  wire selected = ~selSync_r[1];
  wire resetPinLow = ~rstSync_r[1];
  wire lowPower = lpSync_r[1];

  // ****************************************
  // reset pulse qualification
  // ****************************************
  logic [9:0] rstLowCnt_r;
  logic [9:0] rstLowCnt_nxt;
  wire resetHeld = rstLowCnt_r == `RESET_MIN_CYC;

  // count low time on reset pin
  assign rstLowCnt_nxt = !resetPinLow ? 10'h000 :
                         resetHeld ? rstLowCnt_r : rstLowCnt_r + `CNT_ONE;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstLowCnt_r <= 10'h000;
    end else begin
      rstLowCnt_r <= rstLowCnt_nxt;
    end
  end

  // ****************************************
  // initialisation sequence
  // ****************************************
  init_state_t initState_r;
  logic [9:0] initCnt_r;
  wire initDone = initState_r == ST_INIT && initCnt_r == `INIT_LAST;

  // power-up starts in init, same path as a pin reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      initState_r <= ST_INIT;
      initCnt_r <= 10'h000;
    end else if (resetHeld) begin
      initState_r <= ST_INIT;
      initCnt_r <= 10'h000;
    end else begin
      unique case (initState_r)
        ST_INIT: begin
          initState_r <= initDone ? ST_READY : ST_INIT;
          initCnt_r <= initCnt_r + `CNT_ONE;
        end
        ST_READY: begin
        end
      endcase
    end
  end

  assign dataNotReady = initState_r != ST_READY;

  // ****************************************
  // serial access to the map
  // ****************************************
  logic [7:0] memAddr;
  logic [7:0] memWrData;
  logic memWe;
  logic memRe;
  logic [7:0] memRdData;

  two_wire_slave u_slave (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .enable(selected),
    .abort(resetHeld),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOeN(sdaOeN),
    .memAddr(memAddr),
    .memWrData(memWrData),
    .memWe(memWe),
    .memRe(memRe),
    .memRdData(memRdData)
  );

  // never stretches the clock, only pulls data low
  assign sclOut = 1'b0;
  assign sclOeN = 1'b1;
  assign sdaOut = 1'b0;

  function automatic logic addrIs(input logic [7:0] addr, input logic [7:0] target);
    addrIs = addr == target;
  endfunction

  wire userHit = memAddr >= `USER_BASE && memAddr < `USER_BASE + 8'(`USER_DEPTH);
  wire [`USER_IDX_W-1:0] userIdx = memAddr[`USER_IDX_W-1:0];
  wire flagRead = memRe && addrIs(memAddr, `ADDR_FLAGS);
  wire ctrlWrite = memWe && addrIs(memAddr, `ADDR_CTRL);

  // ****************************************
  // settings, flags and user area
  // ****************************************
  logic [7:0] ctrl_r;
  logic [7:0] userMem_r [`USER_DEPTH];
  logic rstDone_r;
  logic rstDone_nxt;
  logic alarm_r;
  logic alarm_nxt;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= `CTRL_RESET;
      for (int i = 0; i < `USER_DEPTH; i++) begin
        userMem_r[i] <= 8'h00;
      end
    end else if (resetHeld) begin
      ctrl_r <= `CTRL_RESET;
      for (int i = 0; i < `USER_DEPTH; i++) begin
        userMem_r[i] <= 8'h00;
      end
    end else begin
      if (ctrlWrite) begin
        ctrl_r <= memWrData;
      end
      if (memWe && userHit) begin
        userMem_r[userIdx] <= memWrData;
      end
    end
  end

  // completion flag set as init ends, read clears, set wins
  assign rstDone_nxt = !resetHeld && (initDone || (rstDone_r && !flagRead));
  assign alarm_nxt = statusAlarm || (alarm_r && !flagRead && !resetHeld);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstDone_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      rstDone_r <= rstDone_nxt;
      alarm_r <= alarm_nxt;
    end
  end

  logic [7:0] statusByte;
  logic [7:0] flagsByte;

  always_comb begin
    statusByte = 8'h00;
    statusByte[`DNR_BIT] = dataNotReady;
    statusByte[`LP_BIT] = lowPower;
    flagsByte = 8'h00;
    flagsByte[`FLAG_RSTDONE] = rstDone_r;
    flagsByte[`FLAG_ALARM] = alarm_r;
  end

  assign memRdData = addrIs(memAddr, `ADDR_STATUS) ? statusByte :
                     addrIs(memAddr, `ADDR_FLAGS) ? flagsByte :
                     addrIs(memAddr, `ADDR_CTRL) ? ctrl_r :
                     userHit ? userMem_r[userIdx] : 8'h00;

  // ****************************************
  // control pins
  // ****************************************
  // open drain: only low or released
  assign attentionIrqNOut = 1'b0;
  assign attentionIrqNOeN = ~(rstDone_r | alarm_r);

  assign presenceNOut = 1'b0;
  assign presenceNOeN = 1'b0;

  logic highPower_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      highPower_r <= 1'b0;
    end else begin
      highPower_r <= !lowPower && !ctrl_r[`CTRL_FORCE_LP] && !dataNotReady;
    end
  end
  assign highPowerEnable = highPower_r;

  // ****************************************
  // checks
  // ****************************************
  chk_reset_sets_dnr: assert property (@(posedge sys_clk) disable iff (!resetn)
    resetHeld |=> dataNotReady) else $error("reset did not set not-ready");
  chk_short_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!dataNotReady && $rose(resetPinLow)) |-> !dataNotReady [*8])
    else $error("short reset pulse acted");
  chk_done_irq: assert property (@(posedge sys_clk) disable iff (!resetn)
    $fell(dataNotReady) |-> !attentionIrqNOeN && !statusByte[`DNR_BIT])
    else $error("no completion interrupt at ready");
  chk_powerup_ready: assert property (@(posedge sys_clk) disable iff (!resetn)
    (initState_r == ST_INIT && initCnt_r == 10'h000 && !resetHeld && !resetPinLow)
    |-> ##[1:600] !attentionIrqNOeN) else $error("no completion after init");
  chk_dnr_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(dataNotReady) |-> dataNotReady [*8]) else $error("init too short");
  chk_low_power: assert property (@(posedge sys_clk) disable iff (!resetn)
    lowPower |=> !highPowerEnable) else $error("power not limited");
  chk_presence_low: assert property (@(posedge sys_clk) disable iff (!resetn)
    !presenceNOeN && !presenceNOut) else $error("presence not grounded");
  chk_alarm_irq: assert property (@(posedge sys_clk) disable iff (!resetn)
    statusAlarm |=> !attentionIrqNOeN) else $error("alarm not signalled");
  chk_irq_open_drain: assert property (@(posedge sys_clk) disable iff (!resetn)
    !attentionIrqNOut) else $error("interrupt driven high");
endmodule

// file: src/mgmt_regs.svh
`ifndef MGMT_REGS_SVH
`define MGMT_REGS_SVH

// bus address of this module (value is arbitrary)
`define DEV_ADDR 7'h50
`define SYS_CLK_MHZ 100
// least low time on the reset pin for a complete reset
`define RESET_MIN_NS 2000
`define RESET_MIN_CYC 10'((`RESET_MIN_NS * `SYS_CLK_MHZ + 999) / 1000)
// internal initialisation time after any reset
`define INIT_NS 5000
`define INIT_LAST 10'((`INIT_NS * `SYS_CLK_MHZ) / 1000 - 1)
`define CNT_ONE 10'h001
`define BYTE_BITS 4'h8
`define LAST_BIT 4'h7
// memory map
`define ADDR_STATUS 8'h02
`define ADDR_FLAGS 8'h03
`define ADDR_CTRL 8'h04
`define USER_BASE 8'h10
`define USER_DEPTH 16
`define USER_IDX_W 4
`define CTRL_RESET 8'h00
// field positions
`define DNR_BIT 0
`define LP_BIT 1
`define FLAG_RSTDONE 0
`define FLAG_ALARM 1
`define CTRL_FORCE_LP 0

`endif

// file: src/mgmt_pkg.sv
package mgmt_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA, S_WDATA_ACK,
    S_RDATA, S_RD_ACK, S_RD_NEXT, S_WAIT
  } twi_state_t;
  typedef enum logic {ST_INIT, ST_READY} init_state_t;
endpackage

// file: src/two_wire_slave.sv
`timescale 1ns/1ns
`include "mgmt_regs.svh"
module two_wire_slave import mgmt_pkg::*; (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic abort,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOeN,
  output logic [7:0] memAddr,
  output logic [7:0] memWrData,
  output logic memWe,
  output logic memRe,
  input wire logic [7:0] memRdData
);
  logic [2:0] sclSync_r;
  logic [2:0] sdaSync_r;
  twi_state_t state_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic readMode_r;
  logic sdaDrive_r;
  logic memWe_r;
  logic memRe_r;
  logic [7:0] memWrData_r;

  wire sclHigh = sclSync_r[1] & sclSync_r[2];
  wire sclRise = sclSync_r[1] & ~sclSync_r[2];
  wire sclFall = ~sclSync_r[1] & sclSync_r[2];
  wire sdaBit = sdaSync_r[1];
  wire startCond = sclHigh & ~sdaSync_r[1] & sdaSync_r[2];
  wire stopCond = sclHigh & sdaSync_r[1] & ~sdaSync_r[2];
  wire byteDone = sclFall && bitCnt_r == `BYTE_BITS;
  wire addrMatch = shift_r[7:1] == `DEV_ADDR;

  assign sdaOeN = ~sdaDrive_r;
  assign memAddr = ptr_r;
  assign memWrData = memWrData_r;
  assign memWe = memWe_r;
  assign memRe = memRe_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
    end else begin
      sclSync_r <= {sclSync_r[1:0], sclIn};
      sdaSync_r <= {sdaSync_r[1:0], sdaIn};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      readMode_r <= 1'b0;
      sdaDrive_r <= 1'b0;
      memWe_r <= 1'b0;
      memRe_r <= 1'b0;
      memWrData_r <= 8'h00;
    end else begin
      memWe_r <= 1'b0;
      memRe_r <= 1'b0;
      if (memWe_r || memRe_r) begin
        ptr_r <= ptr_r + 8'h01;
      end
      if (abort || !enable) begin
        state_r <= S_IDLE;
        sdaDrive_r <= 1'b0;
      end else if (startCond) begin
        state_r <= S_ADDR;
        bitCnt_r <= 4'h0;
        sdaDrive_r <= 1'b0;
      end else if (stopCond) begin
        state_r <= S_IDLE;
        sdaDrive_r <= 1'b0;
      end else begin
        unique case (state_r)
          S_IDLE, S_WAIT: begin
          end
          S_ADDR, S_PTR, S_WDATA: begin
            if (sclRise) begin
              shift_r <= {shift_r[6:0], sdaBit};
              bitCnt_r <= bitCnt_r + 4'h1;
            end else if (byteDone) begin
              sdaDrive_r <= 1'b1;
              if (state_r == S_ADDR) begin
                readMode_r <= shift_r[0];
                state_r <= addrMatch ? S_ADDR_ACK : S_WAIT;
                sdaDrive_r <= addrMatch;
              end else if (state_r == S_PTR) begin
                ptr_r <= shift_r;
                state_r <= S_PTR_ACK;
              end else begin
                memWrData_r <= shift_r;
                memWe_r <= 1'b1;
                state_r <= S_WDATA_ACK;
              end
            end
          end
          S_ADDR_ACK, S_PTR_ACK, S_WDATA_ACK, S_RD_NEXT: begin
            if (sclFall) begin
              bitCnt_r <= 4'h0;
              if ((state_r == S_ADDR_ACK && readMode_r) || state_r == S_RD_NEXT) begin
                shift_r <= memRdData;
                memRe_r <= 1'b1;
                sdaDrive_r <= ~memRdData[7];
                state_r <= S_RDATA;
              end else begin
                sdaDrive_r <= 1'b0;
                state_r <= (state_r == S_ADDR_ACK) ? S_PTR : S_WDATA;
              end
            end
          end
          S_RDATA: begin
            if (sclFall) begin
              if (bitCnt_r == `LAST_BIT) begin
                sdaDrive_r <= 1'b0;
                state_r <= S_RD_ACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sdaDrive_r <= ~shift_r[6];
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          S_RD_ACK: begin
            if (sclRise) begin
              state_r <= sdaBit ? S_WAIT : S_RD_NEXT;
            end
          end
        endcase
      end
    end
  end

  chk_deselect_release: assert property (@(posedge sys_clk) disable iff (!resetn)
    !enable |=> sdaOeN) else $error("sda driven while deselected");
  chk_addr_ack: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_r == S_ADDR && byteDone && addrMatch && enable && !abort && !startCond
     && !stopCond) |=> !sdaOeN ##1 state_r == S_ADDR_ACK)
    else $error("matching address not acknowledged");
endmodule

// file: tb/host_twi_model.sv
`timescale 1ns/1ns
// ****************
// host board side
// ****************
module host_twi_model (
  input wire logic sys_clk,
  input wire logic sclOut,
  input wire logic sclOeN,
  input wire logic sdaOut,
  input wire logic sdaOeN,
  input wire logic irqOut,
  input wire logic irqOeN,
  input wire logic presOut,
  input wire logic presOeN,
  output logic sclLine,
  output logic sdaLine,
  output logic irqLine,
  output logic presLine
);
  logic sclR = 1'b1;
  logic sdaLow = 1'b0;
  assign sclLine = sclR & (sclOeN | sclOut);
  assign sdaLine = ~sdaLow & (sdaOeN | sdaOut);
  assign irqLine = irqOeN | irqOut;
  assign presLine = presOeN | presOut;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // data moves only while the clock is low
  task automatic bitx(input logic b, output logic r);
    sdaLow <= ~b;
    tick(2);
    sclR <= 1'b1;
    tick(4);
    r = sdaLine;
    sclR <= 1'b0;
    tick(2);
  endtask
  task automatic start();
    tick(1);
    sdaLow <= 1'b0;
    tick(2);
    sclR <= 1'b1;
    tick(4);
    sdaLow <= 1'b1;
    tick(4);
    sclR <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    tick(2);
    sclR <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ackBit, output logic [7:0] q,
                      output logic devAck);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(ackBit, r);
    devAck = ~r;
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
`include "mgmt_regs.svh"
`define CHK(nm, e, a) \
  begin \
    checkCount++; \
    if ((a) !== (e)) begin \
      errorCnt++; \
      $display("ERROR %s expected %h seen %h", nm, e, a); \
    end \
  end
module tb_top;
  logic sys_clk, resetn, moduleSelectN, moduleResetN, lowPowerRequest, statusAlarm;
  logic sclIn, sdaIn, sclOut, sclOeN, sdaOut, sdaOeN, presenceNOut, presenceNOeN;
  logic attentionIrqNOut, attentionIrqNOeN, highPowerEnable, dataNotReady;
  logic irqLine, presLine, ok;
  logic [7:0] q, q2;
  int errorCnt = 0;
  int checkCount = 0;
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  row_t rows [5] = '{'{8'h10, 8'hA5, 8'hA5}, '{8'h1F, 8'h5A, 8'h5A},
    '{`ADDR_CTRL, 8'h01, 8'h01}, '{8'h05, 8'hFF, 8'h00}, '{`ADDR_STATUS, 8'hFF, 8'h00}};
  module_mgmt_control_pins i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .moduleSelectN(moduleSelectN), .moduleResetN(moduleResetN),
    .lowPowerRequest(lowPowerRequest), .statusAlarm(statusAlarm), .sclIn(sclIn),
    .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .presenceNOut(presenceNOut), .presenceNOeN(presenceNOeN),
    .attentionIrqNOut(attentionIrqNOut), .attentionIrqNOeN(attentionIrqNOeN),
    .highPowerEnable(highPowerEnable), .dataNotReady(dataNotReady));
  host_twi_model i_host (.sys_clk(sys_clk), .sclOut(sclOut), .sclOeN(sclOeN),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .irqOut(attentionIrqNOut), .irqOeN(attentionIrqNOeN),
    .presOut(presenceNOut), .presOeN(presenceNOeN), .sclLine(sclIn), .sdaLine(sdaIn),
    .irqLine(irqLine), .presLine(presLine));
  // ****************
  // bus tasks
  // ****************
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
    logic [7:0] x;
    logic k1, k2, k3;
    i_host.start();
    i_host.xfer({`DEV_ADDR, 1'b0}, 1'b1, x, k1);
    i_host.xfer(a, 1'b1, x, k2);
    i_host.xfer(d, 1'b1, x, k3);
    i_host.stop();
    ack = k1 & k2 & k3;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    logic k;
    i_host.start();
    i_host.xfer({`DEV_ADDR, 1'b0}, 1'b1, x, k);
    i_host.xfer(a, 1'b1, x, k);
    i_host.start();
    i_host.xfer({`DEV_ADDR, 1'b1}, 1'b1, x, k);
    i_host.xfer(8'hFF, 1'b1, d, k);
    i_host.stop();
  endtask
  // two-byte write then two-byte read, host acks the first read byte
  task automatic burst(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
                       output logic [7:0] q0, output logic [7:0] q1);
    logic [7:0] x;
    logic k;
    i_host.start();
    i_host.xfer({`DEV_ADDR, 1'b0}, 1'b1, x, k);
    i_host.xfer(a, 1'b1, x, k);
    i_host.xfer(d0, 1'b1, x, k);
    i_host.xfer(d1, 1'b1, x, k);
    i_host.stop();
    i_host.start();
    i_host.xfer({`DEV_ADDR, 1'b0}, 1'b1, x, k);
    i_host.xfer(a, 1'b1, x, k);
    i_host.start();
    i_host.xfer({`DEV_ADDR, 1'b1}, 1'b1, x, k);
    i_host.xfer(8'hFF, 1'b0, q0, k);
    i_host.xfer(8'hFF, 1'b1, q1, k);
    i_host.stop();
  endtask
  task automatic waitIrq(input int lim);
    int n;
    n = 0;
    while (irqLine !== 1'b0 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("completion irq", 1'b0, irqLine)
  endtask
  task automatic completeRun();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************
  // clock and watchdog
  // ****************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    errorCnt++;
    $display("ERROR watchdog expected done seen hang");
    completeRun();
  end
  // ****************
  // tests
  // ****************
  initial begin
    resetn = 1'b0;
    moduleSelectN = 1'b0;
    moduleResetN = 1'b1;
    lowPowerRequest = 1'b0;
    statusAlarm = 1'b0;
    @(negedge sys_clk);
    `CHK("dnr in reset", 1'b1, dataNotReady)
    `CHK("irq in reset", 1'b1, irqLine)
    `CHK("presence", 1'b0, presLine)
    `CHK("hpe in reset", 1'b0, highPowerEnable)
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    waitIrq(600);
    `CHK("dnr at irq", 1'b0, dataNotReady)
    rd(`ADDR_FLAGS, q);
    `CHK("reset flag", 8'h01, q)
    @(negedge sys_clk);
    `CHK("irq released", 1'b1, irqLine)
    `CHK("hpe ready", 1'b1, highPowerEnable)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w, ok);
      `CHK("write ack", 1'b1, ok)
      rd(rows[i].a, q);
      `CHK("read back", rows[i].e, q)
    end
    burst(8'h12, 8'h3C, 8'hC3, q, q2);
    `CHK("burst first byte", 8'h3C, q)
    `CHK("burst second byte", 8'hC3, q2)
    @(negedge sys_clk);
    `CHK("hpe forced low", 1'b0, highPowerEnable)
    wr(`ADDR_CTRL, 8'h00, ok);
    lowPowerRequest <= 1'b1;
    rd(`ADDR_STATUS, q);
    `CHK("status low power", 8'h02, q)
    @(negedge sys_clk);
    `CHK("hpe pin low power", 1'b0, highPowerEnable)
    @(posedge sys_clk);
    lowPowerRequest <= 1'b0;
    statusAlarm <= 1'b1;
    @(posedge sys_clk);
    statusAlarm <= 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK("irq on alarm", 1'b0, irqLine)
    rd(`ADDR_FLAGS, q);
    `CHK("alarm flag", 8'h02, q)
    @(negedge sys_clk);
    `CHK("hpe back", 1'b1, highPowerEnable)
    @(posedge sys_clk);
    moduleSelectN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(8'h10, 8'h33, ok);
    `CHK("ack unselected", 1'b0, ok)
    moduleSelectN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(8'h10, q);
    `CHK("user byte kept", 8'hA5, q)
    moduleResetN <= 1'b0;
    repeat (150) @(posedge sys_clk);
    moduleResetN <= 1'b1;
    repeat (5) @(negedge sys_clk);
    `CHK("short pulse dnr", 1'b0, dataNotReady)
    @(posedge sys_clk);
    moduleResetN <= 1'b0;
    repeat (250) @(negedge sys_clk);
    `CHK("dnr held", 1'b1, dataNotReady)
    `CHK("irq during reset", 1'b1, irqLine)
    @(posedge sys_clk);
    moduleResetN <= 1'b1;
    waitIrq(600);
    `CHK("dnr after reset", 1'b0, dataNotReady)
    rd(8'h10, q);
    `CHK("user byte default", 8'h00, q)
    rd(`ADDR_FLAGS, q);
    `CHK("reset done flag", 8'h01, q)
    completeRun();
  end
endmodule
